// >>> include/embd_pkg.sv
// shared constants and types of the external memory bank decode port
package embd_pkg;
    // host bus and memory widths
    localparam int ADDR_WIDTH = 32; // host_addr_width
    localparam int DATA_WIDTH = 32; // host_data_width
    localparam int MAX_MEM_WIDTH = 32; // widest memory subsystem
    localparam int LANE_COUNT = MAX_MEM_WIDTH / 8; // one per byte lane
    localparam int BANK_MAX = 4; // most banks the port can decode
    localparam int CHAN_MAX = 4; // most cache-link channels
    localparam int BUS_MASTER_COUNT = 2; // bus_master_count
    localparam int MASTER_ID_WIDTH = $clog2(BUS_MASTER_COUNT);
    // default bank windows, power-of-two sized and aligned
    localparam logic [0:BANK_MAX-1][31:0] BANK_BASE_DEFAULT = {
        32'h0000_0000, 32'h0010_0000, 32'h0020_0000, 32'h0030_0000};
    localparam logic [0:BANK_MAX-1][31:0] BANK_HIGH_DEFAULT = {
        32'h000F_FFFF, 32'h001F_FFFF, 32'h002F_FFFF, 32'h003F_FFFF};
    // control register window on the host bus
    localparam logic [31:0] REG_WINDOW_BASE = 32'hFFFF_0000;
    localparam logic [31:0] REG_WINDOW_MASK = 32'hFFFF_F000;
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    // control and status fields
    localparam int CTRL_WAIT_LSB = 0;
    localparam int CTRL_WAIT_WIDTH = 4;
    localparam logic [3:0] CTRL_WAIT_RESET = 4'h2;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_BANK_LSB = 4;
    localparam int STATUS_MISS_LSB = 8;
    // access sizes, coded as the bus transfer size
    typedef enum logic [1:0] {SIZE_BYTE, SIZE_HALF, SIZE_WORD} embd_size_t;
    // access engine states
    typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} embd_state_t;
endpackage

// >>> include/embd_acc_if.sv
// access address bundle shared by engine, bank decoder and lane decoder
interface embd_acc_if;
    logic [31:0] addr; // latched access byte address
    logic [1:0] size; // access size code
    logic [0:embd_pkg::BANK_MAX-1] bank_hit; // window match per bank
    logic [0:embd_pkg::LANE_COUNT-1] lane_mask; // lanes touched, 0 = msb
    modport core (output addr, output size, input bank_hit,
        input lane_mask);
    modport dec (input addr, output bank_hit);
    modport lane (input addr, input size, output lane_mask);
endinterface

// >>> hdl/embd_bank_decode.sv
// per-bank window decoder for the latched access address
module embd_bank_decode #(
    parameter int BANK_COUNT = 1,
    parameter logic [0:embd_pkg::BANK_MAX-1][31:0] BANK_BASE_ADDRESS =
        embd_pkg::BANK_BASE_DEFAULT,
    parameter logic [0:embd_pkg::BANK_MAX-1][31:0] BANK_HIGH_ADDRESS =
        embd_pkg::BANK_HIGH_DEFAULT
) (
    embd_acc_if.dec acc // address in, hits out
);
    // each bank compares only against its own pair of limits
    for (genvar b = 0; b < embd_pkg::BANK_MAX; b++) begin : g_bank
        if (b < BANK_COUNT) begin : g_used
            // size mask from base xor high, valid for aligned windows
            localparam logic [31:0] SPAN =
                BANK_BASE_ADDRESS[b] ^ BANK_HIGH_ADDRESS[b];
            assign acc.bank_hit[b] =
                (acc.addr & ~SPAN) == BANK_BASE_ADDRESS[b];
        end else begin : g_unused
            assign acc.bank_hit[b] = 1'b0;
        end
    end
endmodule

// >>> hdl/embd_lane_decode.sv
// byte lane selection for big-endian byte, halfword and word accesses
module embd_lane_decode (
    embd_acc_if.lane acc // address and size in, lane mask out
);
    // lane 0 carries the lowest byte address, the most significant byte
    always_comb begin
        acc.lane_mask = 4'h0;
        unique case (acc.size)
            embd_pkg::SIZE_BYTE: begin
                acc.lane_mask[acc.addr[1:0]] = 1'b1;
            end
            embd_pkg::SIZE_HALF: begin
                acc.lane_mask = acc.addr[1] ? 4'h3 : 4'hC;
            end
            default: begin
                acc.lane_mask = 4'hF; // word, and the unused fourth code
            end
        endcase
    end
endmodule

// >>> hdl/embd_port.sv
// bank decode port: host bus slave, cache-link channels, memory pins
// Function
// - only banks zero to count minus one decode
// - each bank has its own base and high
// - only accesses inside a bank window are served
// - select from decode, chip enable from state
// - one read enable line per configured bank
// - byte, halfword and word accesses supported
// - host data big-endian, bit 31 most significant
// - no memory clock output is generated
// - memory buses labelled big-endian, index zero msb
// - master id and responses sized by master count
// - channels above count ignored, outputs held default
// - data bus split into in, out, enable
// - write strobes and lane enables per byte lane
// - memory address as wide as host address
// - excluded host port ignores memory accesses; control window still answers, ready held high
module embd_port #(
    parameter int BANK_COUNT = 1, // banks in use, 1 to 4
    parameter int CHANNEL_COUNT = 2, // cache-link channels, 0 to 4
    parameter bit HOST_PORT_PRESENT = 1'b1, // host_port_present
    parameter logic [3:0] CHANNEL_WRITE_ENABLE = 4'hF, // per channel
    parameter logic [0:embd_pkg::BANK_MAX-1][31:0] BANK_BASE_ADDRESS =
        embd_pkg::BANK_BASE_DEFAULT, // bank_base_address
    parameter logic [0:embd_pkg::BANK_MAX-1][31:0] BANK_HIGH_ADDRESS =
        embd_pkg::BANK_HIGH_DEFAULT // bank_high_address
) (
    input wire logic REF_CLK, // 25 MHz system clock
    input wire logic NRST, // async reset, active low
    input wire logic HSEL, // slave select
    input wire logic [31:0] HADDR, // byte address
    input wire logic [1:0] HTRANS, // transfer type
    input wire logic HWRITE, // write when high
    input wire logic [2:0] HSIZE, // transfer size
    input wire logic [31:0] HWDATA, // write data
    input wire logic HREADY, // bus ready
    input wire logic [embd_pkg::MASTER_ID_WIDTH-1:0] HMASTER, // master id
    output logic [31:0] HRDATA, // read data
    output logic HREADYOUT, // slave ready
    output logic HRESP, // always okay
    output logic [embd_pkg::BUS_MASTER_COUNT-1:0] MASTER_DONE, // per master
    input wire logic [3:0] CH_REQ, // channel request levels
    input wire logic [3:0] CH_WRITE, // channel write flags
    input wire logic [7:0] CH_SIZE, // two size bits per channel
    input wire logic [127:0] CH_ADDR, // word per channel
    input wire logic [127:0] CH_WDATA, // word per channel
    output logic [3:0] CH_ACK, // one-cycle done pulses
    output logic [31:0] CH_RDATA, // shared read data
    input wire logic [0:embd_pkg::MAX_MEM_WIDTH-1] MEM_DQ_IN, // data in
    output logic [0:embd_pkg::MAX_MEM_WIDTH-1] MEM_DQ_OUT, // data out
    output logic [0:embd_pkg::MAX_MEM_WIDTH-1] MEM_DQ_OE, // drive enables
    output logic [0:embd_pkg::ADDR_WIDTH-1] MEM_ADDR, // byte address
    output logic [0:BANK_COUNT-1] BANK_SELECT_N, // decode selects
    output logic [0:BANK_COUNT-1] BANK_CE, // state chip enables
    output logic [0:BANK_COUNT-1] MEM_READ_ENABLE_N, // output enables
    output logic [0:embd_pkg::LANE_COUNT-1] LANE_WRITE_STROBE_N, // writes
    output logic [0:embd_pkg::LANE_COUNT-1] LANE_ENABLE_N // byte enables
);
    // the memory clock is left to the system, none is made here
    // memory width equals host width, nothing to narrow
    // full byte address goes out; the board picks its shifted slice

    embd_acc_if acc (); // latched access seen by both decoders

    embd_bank_decode #(
        .BANK_COUNT(BANK_COUNT),
        .BANK_BASE_ADDRESS(BANK_BASE_ADDRESS),
        .BANK_HIGH_ADDRESS(BANK_HIGH_ADDRESS)
    ) u_bank (
        .acc(acc)
    );

    embd_lane_decode u_lane (
        .acc(acc)
    );

    // engine state
    embd_pkg::embd_state_t state; // access phase
    logic acc_write; // access writes memory
    logic [31:0] acc_wdata; // word to drive
    logic src_host; // access came from the host bus
    logic [1:0] src_ch; // granted channel
    logic [3:0] cnt; // strobe cycles left
    logic [31:0] rdata; // captured memory word
    logic acc_hit; // address inside some bank
    logic active; // memory pins in use

    // host side
    logic ap_take; // address phase accepted
    logic ap_reg; // address falls in the control window
    logic host_pend; // host memory access outstanding
    logic [embd_pkg::MASTER_ID_WIDTH-1:0] host_master; // requester id
    logic [31:0] host_addr; // latched host address
    logic [1:0] host_size; // latched host size
    logic host_write; // latched host direction
    logic reg_wr_pend; // control write in data phase
    logic [11:0] reg_wr_off; // offset of that write

    // registers
    logic [3:0] ctrl_wait; // extra strobe cycles
    logic [7:0] miss_cnt; // accesses outside every window
    logic [1:0] last_bank; // bank of the latest hit

    // channels
    logic [3:0] ch_live; // request from a channel in use
    logic [3:0] ch_wr_ok; // write allowed on that channel
    logic next_grant_valid; // some channel may start
    logic [1:0] next_grant; // lowest waiting channel

    assign ap_take = HSEL && HTRANS[1] && HREADY;
    assign ap_reg = (HADDR & embd_pkg::REG_WINDOW_MASK) ==
        embd_pkg::REG_WINDOW_BASE;
    assign acc_hit = |acc.bank_hit;
    assign active = (state != embd_pkg::ST_IDLE) && acc_hit;
    assign HREADYOUT = !host_pend; // stall only while a host memory access is outstanding
    assign HRESP = 1'b0;

    // unused channels see no request and may never write
    for (genvar i = 0; i < embd_pkg::CHAN_MAX; i++) begin : g_chan
        if (i < CHANNEL_COUNT) begin : g_used
            assign ch_live[i] = CH_REQ[i] && !CH_ACK[i];
            assign ch_wr_ok[i] = CH_WRITE[i] && CHANNEL_WRITE_ENABLE[i];
        end else begin : g_unused
            assign ch_live[i] = 1'b0;
            assign ch_wr_ok[i] = 1'b0;
        end
    end

    // fixed priority, lowest channel first; host goes before any
    always_comb begin
        next_grant_valid = 1'b0;
        next_grant = 2'h0;
        for (int i = embd_pkg::CHAN_MAX - 1; i >= 0; i--) begin
            if (ch_live[i]) begin
                next_grant_valid = 1'b1;
                next_grant = 2'(i);
            end
        end
    end

    // host address phase capture
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            host_pend <= 1'b0;
            host_master <= '0;
            host_addr <= 32'h0000_0000;
            host_size <= 2'h0;
            host_write <= 1'b0;
        end else if (ap_take && !ap_reg && HOST_PORT_PRESENT) begin
            host_pend <= 1'b1; // memory candidate, window checked later
            host_master <= HMASTER;
            host_addr <= HADDR;
            host_size <= HSIZE[1:0];
            host_write <= HWRITE;
        end else if (state == embd_pkg::ST_HOLD && src_host) begin
            host_pend <= 1'b0; // cannot meet a new capture: bus stalled
        end
    end

    // control register writes land in the data phase
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            reg_wr_pend <= 1'b0;
            reg_wr_off <= 12'h000;
            ctrl_wait <= embd_pkg::CTRL_WAIT_RESET;
        end else begin
            reg_wr_pend <= ap_take && ap_reg && HWRITE;
            reg_wr_off <= HADDR[11:0];
            if (reg_wr_pend && reg_wr_off == embd_pkg::CTRL_OFFSET) begin
                ctrl_wait <= HWDATA[embd_pkg::CTRL_WAIT_LSB +:
                    embd_pkg::CTRL_WAIT_WIDTH];
            end
        end
    end

    // read data for the host: registers answer at once, memory later
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            HRDATA <= 32'h0000_0000;
        end else if (ap_take && ap_reg && !HWRITE) begin
            HRDATA <= 32'h0000_0000;
            if (HADDR[11:0] == embd_pkg::CTRL_OFFSET) begin
                HRDATA[embd_pkg::CTRL_WAIT_LSB +:
                    embd_pkg::CTRL_WAIT_WIDTH] <= ctrl_wait;
            end else if (HADDR[11:0] == embd_pkg::STATUS_OFFSET) begin
                HRDATA[embd_pkg::STATUS_BUSY_BIT] <=
                    state != embd_pkg::ST_IDLE;
                HRDATA[embd_pkg::STATUS_BANK_LSB +: 2] <= last_bank;
                HRDATA[embd_pkg::STATUS_MISS_LSB +: 8] <= miss_cnt;
            end
        end else if (ap_take) begin
            HRDATA <= 32'h0000_0000; // excluded port or write reads zero
        end else if (state == embd_pkg::ST_HOLD && src_host) begin
            HRDATA <= rdata; // byte address n+0 sits in bits 31:24
        end
    end

    // access engine: setup, strobe for wait+1 cycles, hold
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            state <= embd_pkg::ST_IDLE;
            acc.addr <= 32'h0000_0000;
            acc.size <= 2'h0;
            acc_write <= 1'b0;
            acc_wdata <= 32'h0000_0000;
            src_host <= 1'b0;
            src_ch <= 2'h0;
            cnt <= 4'h0;
        end else begin
            unique case (state)
                embd_pkg::ST_IDLE: begin
                    if (host_pend) begin
                        state <= embd_pkg::ST_SETUP;
                        acc.addr <= host_addr;
                        acc.size <= host_size;
                        acc_write <= host_write;
                        acc_wdata <= HWDATA; // data phase of the host
                        src_host <= 1'b1;
                    end else if (next_grant_valid) begin
                        state <= embd_pkg::ST_SETUP;
                        acc.addr <= CH_ADDR[32*next_grant +: 32];
                        acc.size <= CH_SIZE[2*next_grant +: 2];
                        acc_write <= ch_wr_ok[next_grant];
                        acc_wdata <= CH_WDATA[32*next_grant +: 32];
                        src_host <= 1'b0;
                        src_ch <= next_grant;
                    end
                end
                embd_pkg::ST_SETUP: begin
                    cnt <= ctrl_wait;
                    // outside every window: skip the pins entirely
                    state <= acc_hit ? embd_pkg::ST_STROBE :
                        embd_pkg::ST_HOLD;
                end
                embd_pkg::ST_STROBE: begin
                    if (cnt == 4'h0) begin
                        state <= embd_pkg::ST_HOLD;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                embd_pkg::ST_HOLD: begin
                    state <= embd_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // memory read capture on the last strobe cycle
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rdata <= 32'h0000_0000;
        end else if (state == embd_pkg::ST_SETUP) begin
            rdata <= 32'h0000_0000; // a miss reads back zero
        end else if (state == embd_pkg::ST_STROBE && cnt == 4'h0 &&
                !acc_write) begin
            rdata <= MEM_DQ_IN; // dq[0] lands in bit 31
        end
    end

    // status bookkeeping
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            miss_cnt <= 8'h00;
            last_bank <= 2'h0;
        end else if (state == embd_pkg::ST_SETUP) begin
            if (!acc_hit) begin
                miss_cnt <= miss_cnt + 8'h01; // wraps, diagnostic only
            end
            for (int b = 0; b < embd_pkg::BANK_MAX; b++) begin
                if (acc.bank_hit[b]) begin
                    last_bank <= 2'(b);
                end
            end
        end
    end

    // completion pulses to the requester
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            MASTER_DONE <= '0;
            CH_ACK <= 4'h0;
            CH_RDATA <= 32'h0000_0000;
        end else begin
            MASTER_DONE <= '0;
            CH_ACK <= 4'h0;
            if (state == embd_pkg::ST_HOLD) begin
                if (src_host) begin
                    MASTER_DONE[host_master] <= 1'b1;
                end else begin
                    CH_ACK[src_ch] <= 1'b1; // only live channels
                    CH_RDATA <= rdata;
                end
            end
        end
    end

    // memory pins; controls and drive enables released while idle, address and data out keep the last access
    assign MEM_ADDR = acc.addr;
    assign MEM_DQ_OUT = acc_wdata;
    assign MEM_DQ_OE = {embd_pkg::MAX_MEM_WIDTH{acc_write && active &&
        (state == embd_pkg::ST_STROBE || state == embd_pkg::ST_HOLD)}};
    assign LANE_ENABLE_N = active ? ~acc.lane_mask : 4'hF;
    assign LANE_WRITE_STROBE_N = (active && acc_write &&
        state == embd_pkg::ST_STROBE) ? ~acc.lane_mask : 4'hF;

    for (genvar b = 0; b < BANK_COUNT; b++) begin : g_pin
        assign BANK_SELECT_N[b] = !(active && acc.bank_hit[b]);
        assign BANK_CE[b] = active && acc.bank_hit[b] &&
            state == embd_pkg::ST_STROBE;
        assign MEM_READ_ENABLE_N[b] = !(active && !acc_write &&
            acc.bank_hit[b] && state != embd_pkg::ST_HOLD);
    end

    // checks
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    sequence s_write_setup;
        state == embd_pkg::ST_SETUP && acc_write && acc_hit;
    endsequence
    sequence s_strobe_end;
        state == embd_pkg::ST_HOLD && LANE_WRITE_STROBE_N == 4'hF;
    endsequence
    sequence s_host_mem;
        ap_take && !ap_reg && HOST_PORT_PRESENT;
    endsequence

    property p_idle_quiet;
        state == embd_pkg::ST_IDLE |-> &BANK_SELECT_N && !(|BANK_CE) &&
            &MEM_READ_ENABLE_N && LANE_WRITE_STROBE_N == 4'hF &&
            !(|MEM_DQ_OE);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("pins active while idle");

    property p_one_bank;
        $onehot0(~BANK_SELECT_N) && $onehot0(BANK_CE);
    endproperty
    a_one_bank: assert property (p_one_bank)
        else $error("more than one bank selected");

    property p_miss;
        state == embd_pkg::ST_SETUP && !acc_hit |->
            &BANK_SELECT_N ##1 state == embd_pkg::ST_HOLD && !(|MEM_DQ_OE);
    endproperty
    a_miss: assert property (p_miss)
        else $error("access outside windows reached the memory");

    property p_ce_in_strobe;
        |BANK_CE |-> state == embd_pkg::ST_STROBE && BANK_CE == ~BANK_SELECT_N;
    endproperty
    a_ce_in_strobe: assert property (p_ce_in_strobe)
        else $error("chip enable outside strobe");

    property p_write_strobe;
        s_write_setup |=> LANE_WRITE_STROBE_N == ~acc.lane_mask
            ##[1:16] s_strobe_end;
    endproperty
    a_write_strobe: assert property (p_write_strobe)
        else $error("write strobe sequence wrong");

    property p_byte_lane;
        state == embd_pkg::ST_SETUP && acc_hit &&
            acc.size == embd_pkg::SIZE_BYTE && acc.addr[1:0] == 2'h0 |->
            LANE_ENABLE_N == 4'h7;
    endproperty
    a_byte_lane: assert property (p_byte_lane)
        else $error("byte zero not on the msb lane");

    property p_word_lanes;
        state == embd_pkg::ST_SETUP && acc_hit &&
            acc.size == embd_pkg::SIZE_WORD |-> LANE_ENABLE_N == 4'h0;
    endproperty
    a_word_lanes: assert property (p_word_lanes)
        else $error("word access lost a lane");

    property p_unused_ch;
        (CH_ACK & ~((4'h1 << CHANNEL_COUNT) - 4'h1)) == 4'h0;
    endproperty
    a_unused_ch: assert property (p_unused_ch)
        else $error("unused channel acknowledged");

    property p_host_off;
        !HOST_PORT_PRESENT |-> MASTER_DONE == '0 && HREADYOUT;
    endproperty
    a_host_off: assert property (p_host_off)
        else $error("excluded host port answered");

    property p_host_done;
        s_host_mem |=> !HREADYOUT ##[2:37] $rose(HREADYOUT) && $past(
            state == embd_pkg::ST_HOLD);
    endproperty
    a_host_done: assert property (p_host_done)
        else $error("host access not finished in time");
endmodule

// >>> test/embd_mem_model.sv
// two-bank word memory answering the port's memory pins
module embd_mem_model (
    input wire logic REF_CLK, // system clock
    input wire logic [0:31] MEM_ADDR, // byte address
    input wire logic [0:31] MEM_DQ_OUT, // write data
    input wire logic [0:1] BANK_SELECT_N, // decode selects
    input wire logic [0:1] MEM_READ_ENABLE_N, // output enables
    input wire logic [0:3] LANE_WRITE_STROBE_N, // lane writes
    output logic [0:31] MEM_DQ_IN // read data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [0:31] mem [0:15]; // eight words per bank
    logic [0:31] last = 32'h0; // last level on the bus
    logic [3:0] idx; // word index
    logic rd; // a selected bank is reading
    // windows kept aligned 1 MiB, bus as wide as the host
    // word lines take the byte address shifted by two
    assign idx = {MEM_ADDR[11], MEM_ADDR[27:29]};
    assign rd = ((BANK_SELECT_N | MEM_READ_ENABLE_N) != 2'h3);
    // released bus flips each cycle so stale data cannot match
    assign MEM_DQ_IN = rd ? mem[idx] : ~last;
    // lane writes land only while a bank is selected
    always @(posedge REF_CLK) begin
        last <= MEM_DQ_IN;
        for (int l = 0; l < 4; l++)
            if (!LANE_WRITE_STROBE_N[l] && BANK_SELECT_N != 2'h3)
                mem[idx][8*l +: 8] <= MEM_DQ_OUT[8*l +: 8];
    end
endmodule

// >>> test/embd_port_test.sv
// self-checking bench of the bank decode port
module embd_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic REF_CLK = 1'b0, NRST = 1'b0, HSEL = 1'b0, HWRITE = 1'b0; // bus
    logic [1:0] HTRANS = 2'h0; // transfer type
    logic [2:0] HSIZE = 3'h2; // transfer size
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0; // address, write data
    logic [embd_pkg::MASTER_ID_WIDTH-1:0] HMASTER = 1'h1; // master one
    logic [3:0] CH_REQ = 4'h0, CH_WRITE = 4'h0; // channel controls
    logic [7:0] CH_SIZE = 8'hAA; // word size on every channel
    logic [127:0] CH_ADDR = 128'h0, CH_WDATA = 128'h0; // channel fields
    logic [31:0] HRDATA, CH_RDATA, rd; // read words
    logic HREADYOUT, HRESP; // slave answer
    logic [1:0] MASTER_DONE, done; // completion per master
    logic [3:0] CH_ACK; // channel done pulses
    logic [0:31] MEM_DQ_IN, MEM_DQ_OUT, MEM_DQ_OE, MEM_ADDR; // memory bus
    logic [0:1] BANK_SELECT_N, BANK_CE, MEM_READ_ENABLE_N; // per bank
    logic [0:3] LANE_WRITE_STROBE_N, LANE_ENABLE_N; // per lane
    int n_fail = 0, total_checks = 0, sel_cycles = 0; // counters
    embd_port #(.BANK_COUNT(2), .CHANNEL_COUNT(2)) dut (.REF_CLK(REF_CLK),
        .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HMASTER(HMASTER), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MASTER_DONE(MASTER_DONE),
        .CH_REQ(CH_REQ), .CH_WRITE(CH_WRITE), .CH_SIZE(CH_SIZE),
        .CH_ADDR(CH_ADDR), .CH_WDATA(CH_WDATA), .CH_ACK(CH_ACK),
        .CH_RDATA(CH_RDATA), .MEM_DQ_IN(MEM_DQ_IN), .MEM_DQ_OUT(MEM_DQ_OUT),
        .MEM_DQ_OE(MEM_DQ_OE), .MEM_ADDR(MEM_ADDR),
        .BANK_SELECT_N(BANK_SELECT_N), .BANK_CE(BANK_CE),
        .MEM_READ_ENABLE_N(MEM_READ_ENABLE_N),
        .LANE_WRITE_STROBE_N(LANE_WRITE_STROBE_N),
        .LANE_ENABLE_N(LANE_ENABLE_N));
    embd_mem_model mem (.REF_CLK(REF_CLK), .MEM_ADDR(MEM_ADDR),
        .MEM_DQ_OUT(MEM_DQ_OUT), .BANK_SELECT_N(BANK_SELECT_N),
        .MEM_READ_ENABLE_N(MEM_READ_ENABLE_N),
        .LANE_WRITE_STROBE_N(LANE_WRITE_STROBE_N), .MEM_DQ_IN(MEM_DQ_IN));
    always #20 REF_CLK = ~REF_CLK;
    // count cycles with any bank selected
    always @(posedge REF_CLK) if (BANK_SELECT_N !== 2'h3) sel_cycles++;
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // ready seen late in the cycle equals its level at the next edge
    task automatic wait_rdy(output logic [31:0] d);
        logic ok;
        ok = 1'b0;
        for (int n = 0; n < 60 && !ok; n++) begin
            @(negedge REF_CLK);
            ok = (HREADYOUT === 1'b1);
            d = HRDATA;
            done = MASTER_DONE;
            @(posedge REF_CLK);
        end
        if (!ok) begin
            chk("ready timeout", 32'h1, 32'h0);
            test_done();
        end
    endtask
    // one single transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [31:0] a,
        input logic [2:0] sz, input logic [31:0] wd);
        logic [31:0] d;
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= w;
        HSIZE <= sz;
        wait_rdy(d);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        wait_rdy(rd);
    endtask
    task t_reset; // idle pins after reset
        chk("select_n", 32'h3, {30'h0, BANK_SELECT_N});
        chk("ce", 32'h0, {30'h0, BANK_CE});
        chk("read_en_n", 32'h3, {30'h0, MEM_READ_ENABLE_N});
        chk("dq_oe", 32'h0, MEM_DQ_OE);
        chk("strobe_n", 32'hF, {28'h0, LANE_WRITE_STROBE_N});
        chk("lane_en_n", 32'hF, {28'h0, LANE_ENABLE_N});
        chk("hresp", 32'h0, {31'h0, HRESP});
        $display("test reset done");
    endtask
    task t_banks; // back-to-back words in two windows
        xfer(1'b1, 32'h0000_0010, 3'h2, 32'h1122_3344);
        xfer(1'b1, 32'h0010_0010, 3'h2, 32'hA5A5_0F0F);
        xfer(1'b0, 32'h0000_0010, 3'h2, 32'h0);
        chk("bank0 word", 32'h1122_3344, rd);
        chk("master done", 32'h2, {30'h0, done});
        xfer(1'b0, 32'h0010_0010, 3'h2, 32'h0);
        chk("bank1 word", 32'hA5A5_0F0F, rd);
        $display("test banks done");
    endtask
    task t_sizes; // byte and halfword lanes, big-endian
        xfer(1'b1, 32'h0000_0011, 3'h0, 32'h0055_0000);
        xfer(1'b1, 32'h0000_0012, 3'h1, 32'h0000_AABB);
        xfer(1'b0, 32'h0000_0010, 3'h2, 32'h0);
        chk("merged word", 32'h1155_AABB, rd);
        xfer(1'b0, 32'h0000_0010, 3'h0, 32'h0);
        chk("byte zero", 32'h11, {24'h0, rd[31:24]});
        xfer(1'b0, 32'h0000_0013, 3'h0, 32'h0);
        chk("byte read", 32'hBB, {24'h0, rd[7:0]});
        $display("test sizes done");
    endtask
    task t_miss; // bank two lies beyond the configured count
        int s;
        s = sel_cycles;
        xfer(1'b1, 32'h0020_0000, 3'h2, 32'hDEAD_BEEF);
        xfer(1'b0, 32'h0020_0000, 3'h2, 32'h0);
        chk("miss read", 32'h0, rd);
        chk("miss selects", 32'h0, sel_cycles - s);
        xfer(1'b0, 32'hFFFF_0004, 3'h2, 32'h0);
        chk("miss count", 32'h0000_0200, rd);
        $display("test miss done");
    endtask
    task t_chan; // live channel served, unused one ignored
        logic ok;
        logic [3:0] acks;
        ok = 1'b0;
        acks = 4'h0;
        CH_ADDR[31:0] <= 32'h0010_0010;
        CH_REQ <= 4'h9;
        for (int n = 0; n < 60 && !ok; n++) begin
            @(negedge REF_CLK);
            ok = (CH_ACK[0] === 1'b1);
            acks = acks | CH_ACK;
            if (ok) chk("ch0 data", 32'hA5A5_0F0F, CH_RDATA);
            @(posedge REF_CLK);
        end
        CH_REQ <= 4'h8;
        chk("ch0 ack", 32'h1, {31'h0, ok});
        repeat (30) @(negedge REF_CLK) acks = acks | CH_ACK;
        chk("ch3 ack", 32'h0, {31'h0, acks[3]});
        @(posedge REF_CLK) CH_REQ <= 4'h0;
        $display("test channels done");
    endtask
    initial begin
        repeat (3) @(posedge REF_CLK);
        NRST <= 1'b1;
        @(posedge REF_CLK);
        t_reset();
        t_banks();
        t_sizes();
        t_miss();
        t_chan();
        test_done();
    end
endmodule
